// ==== rtl/ipm_top.sv ====
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "ipm_map.svh"

module ipm_top #(
   parameter int AW     = 34,   // APB byte address width (index times four)
   parameter int NSLOT  = 64,   // Sixteen registers of four nibbles
   parameter int NEXT   = 8,    // External request lines
   parameter int SLOT_W = 6     // Width of a slot number
) (
   input  wire logic                 clock,
   input  wire logic                 resetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [AW-1:0]        paddr,
   input  wire logic [31:0]          pwdata,
   input  wire logic [3:0]           pstrb,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic [NEXT-1:0]      ext_line,
   input  wire logic [NSLOT-1:0]     src_req,
   input  wire logic                 ep1_full_transfer_end,
   input  wire logic                 ep2_empty_transfer_end,
   output logic                      core_req,
   output ipm_pkg::ipm_level_t       core_level,
   output logic      [SLOT_W-1:0]    core_slot,
   output logic      [15:0]          control0,
   output logic      [15:0]          control1,
   output logic      [15:0]          bank_control,
   output logic      [15:0]          bank_number,
   output logic                      irq
);
   import ipm_pkg::*;

   // Register storage
   ipm_word_t              prio_r [16];      // Priority registers in map order
   ipm_word_t              ctl0_r;           // Control register 0
   ipm_word_t              ctl1_r;           // Control register 1
   ipm_word_t              bankctl_r;        // Bank control
   ipm_word_t              banknum_r;        // Bank number
   logic [NEXT-1:0]        extflg_r;         // External request flags
   logic [NEXT-1:0]        extseen_r;        // Flags read back as one
   logic [NEXT-1:0]        extline_r;        // Previous line level for edges
   logic [1:0]             usbflg_r;         // Endpoint transfer-end flags
   logic [1:0]             usbseen_r;        // Endpoint flags read as one
   logic [`IPM_ST_W-1:0]   stat_r;           // Sticky interrupt status
   logic [`IPM_ST_W-1:0]   mask_r;           // Interrupt mask
   logic                   ready_r;          // Second access cycle marker
   logic [31:0]            prdata_r;         // Registered read data
   logic                   pslverr_r;        // Registered error answer
   logic                   core_req_r;       // Registered arbitration result
   ipm_level_t             core_level_r;
   logic [SLOT_W-1:0]      core_slot_r;

   // Decode of the current address
   ipm_kind_e              kind;
   logic [3:0]             pidx;
   logic                   acc_ok;           // Access size allowed
   logic                   done;             // Transfer completes this edge
   logic                   wr_do;            // Write takes effect this edge
   logic                   rd_do;            // Read completes this edge
   logic [15:0]            wval;             // Halfword being written
   logic [15:0]            rval;             // Halfword being read
   logic [NEXT-1:0]        ext_rise;         // Rising edges on external lines
   logic [NSLOT-1:0]       req_raw;          // Requests before masking
   logic [NSLOT-1:0]       req_live;         // Requests on live nibbles

   // Map a word index to a register kind
   function automatic ipm_kind_e dec_kind(input logic [31:0] idx);
      case (idx)
         `IPM_IDX_PRIO01, `IPM_IDX_PRIO02, `IPM_IDX_PRIO05, `IPM_IDX_PRIO06,
         `IPM_IDX_PRIO07, `IPM_IDX_PRIO08, `IPM_IDX_PRIO09, `IPM_IDX_PRIO10,
         `IPM_IDX_PRIO11, `IPM_IDX_PRIO12, `IPM_IDX_PRIO13, `IPM_IDX_PRIO14,
         `IPM_IDX_PRIO15, `IPM_IDX_PRIO16, `IPM_IDX_PRIO17,
         `IPM_IDX_PRIO18:   dec_kind = IPM_K_PRIO;
         `IPM_IDX_CTL0:     dec_kind = IPM_K_CTL0;
         `IPM_IDX_CTL1:     dec_kind = IPM_K_CTL1;
         `IPM_IDX_EXTFLG:   dec_kind = IPM_K_EXTFLG;
         `IPM_IDX_BANKCTL:  dec_kind = IPM_K_BANKCTL;
         `IPM_IDX_BANKNUM:  dec_kind = IPM_K_BANKNUM;
         `IPM_IDX_USBFLG:   dec_kind = IPM_K_USBFLG;
         `IPM_IDX_IRQSTAT:  dec_kind = IPM_K_STAT;
         `IPM_IDX_IRQMASK:  dec_kind = IPM_K_MASK;
         default:           dec_kind = IPM_K_NONE;
      endcase
   endfunction

   // Map a priority register index to its storage slot
   function automatic logic [3:0] dec_prio(input logic [31:0] idx);
      case (idx)
         `IPM_IDX_PRIO01: dec_prio = 4'h0;
         `IPM_IDX_PRIO02: dec_prio = 4'h1;
         `IPM_IDX_PRIO05: dec_prio = 4'h2;
         `IPM_IDX_PRIO06: dec_prio = 4'h3;
         `IPM_IDX_PRIO07: dec_prio = 4'h4;
         `IPM_IDX_PRIO08: dec_prio = 4'h5;
         `IPM_IDX_PRIO09: dec_prio = 4'h6;
         `IPM_IDX_PRIO10: dec_prio = 4'h7;
         `IPM_IDX_PRIO11: dec_prio = 4'h8;
         `IPM_IDX_PRIO12: dec_prio = 4'h9;
         `IPM_IDX_PRIO13: dec_prio = 4'hA;
         `IPM_IDX_PRIO14: dec_prio = 4'hB;
         `IPM_IDX_PRIO15: dec_prio = 4'hC;
         `IPM_IDX_PRIO16: dec_prio = 4'hD;
         `IPM_IDX_PRIO17: dec_prio = 4'hE;
         default:         dec_prio = 4'hF;
      endcase
   endfunction

   // Writable nibbles of each priority register; reserved ones stay zero
   function automatic logic [15:0] prio_wmask(input logic [3:0] p);
      case (p)
         4'h2:    prio_wmask = `IPM_WMASK_PRIO05;
         4'hA:    prio_wmask = `IPM_WMASK_PRIO13;
         4'hB:    prio_wmask = `IPM_WMASK_PRIO14;
         4'hC:    prio_wmask = `IPM_WMASK_PRIO15;
         4'hD:    prio_wmask = `IPM_WMASK_PRIO16;
         4'hE:    prio_wmask = `IPM_WMASK_PRIO17;
         default: prio_wmask = `IPM_WMASK_FULL;
      endcase
   endfunction

   // Registers that also take a full word access
   function automatic logic wide_ok(input ipm_kind_e k, input logic [3:0] p);
      case (k)
         IPM_K_CTL0, IPM_K_BANKCTL, IPM_K_STAT, IPM_K_MASK:
            wide_ok = 1'b1;
         IPM_K_PRIO:
            wide_ok = (p == 4'h0) || (p == 4'h3) || (p == 4'h5) || (p == 4'h7) ||
                      (p == 4'h9) || (p == 4'hB) || (p == 4'hD);
         default:
            wide_ok = 1'b0;
      endcase
   endfunction

   // Address decode and access size check
   always_comb begin
      kind = dec_kind(paddr[AW-1:2]);
      pidx = dec_prio(paddr[AW-1:2]);
      wval = pwdata[15:0];
      if (kind == IPM_K_NONE) begin
         acc_ok = 1'b0;                              // Unmapped word
      end else if (!pwrite) begin
         acc_ok = 1'b1;                              // Reads carry no size
      end else if (pstrb == `IPM_STRB_HALF) begin
         acc_ok = 1'b1;
      end else if (pstrb == `IPM_STRB_WORD) begin
         acc_ok = wide_ok(kind, pidx);
      end else begin
         acc_ok = 1'b0;                              // Byte and odd strobes
      end
   end

   // Read multiplexer
   always_comb begin
      case (kind)
         IPM_K_PRIO:    rval = prio_r[pidx];
         IPM_K_CTL0:    rval = ctl0_r;
         IPM_K_CTL1:    rval = ctl1_r;
         IPM_K_EXTFLG:  rval = {{(16-NEXT){1'b0}}, extflg_r};
         IPM_K_BANKCTL: rval = bankctl_r;
         IPM_K_BANKNUM: rval = banknum_r;
         IPM_K_USBFLG:  rval = {14'h0000, usbflg_r};
         IPM_K_STAT:    rval = {{(16-`IPM_ST_W){1'b0}}, stat_r};
         IPM_K_MASK:    rval = {{(16-`IPM_ST_W){1'b0}}, mask_r};
         default:       rval = 16'h0000;
      endcase
   end

   // Transfer completes in the second access cycle
   assign done  = psel && penable && ready_r;
   assign wr_do = done && pwrite && acc_ok;
   assign rd_do = done && !pwrite && acc_ok;

   // One wait state, so the read data and error come from flip-flops
   always_ff @(posedge clock) begin
      if (!resetn) begin
         ready_r   <= 1'b0;
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else if (psel && penable && !ready_r) begin
         ready_r   <= 1'b1;
         prdata_r  <= (acc_ok && !pwrite) ? {16'h0000, rval} : 32'h0000_0000;
         pslverr_r <= !acc_ok;
      end else begin
         ready_r   <= 1'b0;
         pslverr_r <= 1'b0;
      end
   end

   assign pready  = ready_r;
   assign prdata  = prdata_r;
   assign pslverr = pslverr_r;

   // Priority registers; reserved nibbles never take a written one
   always_ff @(posedge clock) begin
      if (!resetn) begin
         for (int i = 0; i < 16; i++) begin
            prio_r[i] <= `IPM_RST_ZERO;
         end
      end else if (wr_do && kind == IPM_K_PRIO) begin
         prio_r[pidx] <= wval & prio_wmask(pidx);
      end
   end

   // Control and bank registers, plain read/write
   always_ff @(posedge clock) begin
      if (!resetn) begin
         ctl0_r    <= `IPM_RST_CTL0;
         ctl1_r    <= `IPM_RST_ZERO;
         bankctl_r <= `IPM_RST_ZERO;
         banknum_r <= `IPM_RST_ZERO;
      end else if (wr_do) begin
         case (kind)
            IPM_K_CTL0:    ctl0_r    <= wval;
            IPM_K_CTL1:    ctl1_r    <= wval;
            IPM_K_BANKCTL: bankctl_r <= wval;
            IPM_K_BANKNUM: banknum_r <= wval;
            default:       ;
         endcase
      end
   end

   assign control0     = ctl0_r;
   assign control1     = ctl1_r;
   assign bank_control = bankctl_r;
   assign bank_number  = banknum_r;

   // Edge detect on external lines; inputs already synchronous
   always_ff @(posedge clock) begin
      if (!resetn) begin
         extline_r <= '0;
      end else begin
         extline_r <= ext_line;
      end
   end

   assign ext_rise = ext_line & ~extline_r;

   // External request flags: edge sets, read-one then write-zero clears
   // A new edge in the clearing cycle wins, so no request is dropped
   always_ff @(posedge clock) begin
      if (!resetn) begin
         extflg_r  <= '0;
         extseen_r <= '0;
      end else begin
         for (int i = 0; i < NEXT; i++) begin
            if (ext_rise[i]) begin
               extflg_r[i]  <= 1'b1;
            end else if (wr_do && kind == IPM_K_EXTFLG && !wval[i] && extseen_r[i]) begin
               extflg_r[i]  <= 1'b0;
               extseen_r[i] <= 1'b0;
            end else if (rd_do && kind == IPM_K_EXTFLG && extflg_r[i]) begin
               extseen_r[i] <= 1'b1;
            end
         end
      end
   end

   // Endpoint transfer-end flags, same discipline as the external flags
   always_ff @(posedge clock) begin
      if (!resetn) begin
         usbflg_r  <= 2'b00;
         usbseen_r <= 2'b00;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (i == 0 ? ep1_full_transfer_end : ep2_empty_transfer_end) begin
               usbflg_r[i]  <= 1'b1;
            end else if (wr_do && kind == IPM_K_USBFLG && !wval[i] && usbseen_r[i]) begin
               usbflg_r[i]  <= 1'b0;
               usbseen_r[i] <= 1'b0;
            end else if (rd_do && kind == IPM_K_USBFLG && usbflg_r[i]) begin
               usbseen_r[i] <= 1'b1;
            end
         end
      end
   end

   // Sticky status, write one to clear; a set in the same cycle wins
   always_ff @(posedge clock) begin
      if (!resetn) begin
         stat_r <= '0;
      end else begin
         for (int i = 0; i < `IPM_ST_W; i++) begin
            if ((i == `IPM_ST_EXT && |ext_rise) ||
                (i == `IPM_ST_USB && (ep1_full_transfer_end || ep2_empty_transfer_end)) ||
                (i == `IPM_ST_ERR && done && !acc_ok)) begin
               stat_r[i] <= 1'b1;
            end else if (wr_do && kind == IPM_K_STAT && wval[i]) begin
               stat_r[i] <= 1'b0;
            end
         end
      end
   end

   // Interrupt mask
   always_ff @(posedge clock) begin
      if (!resetn) begin
         mask_r <= '0;
      end else if (wr_do && kind == IPM_K_MASK) begin
         mask_r <= wval[`IPM_ST_W-1:0];
      end
   end

   assign irq = |(stat_r & mask_r);

   // Request vector: flag registers feed their own slots
   always_comb begin
      req_raw = src_req;
      req_raw[NEXT-1:0]     = extflg_r;
      req_raw[`IPM_SLOT_EP1] = usbflg_r[0];
      req_raw[`IPM_SLOT_EP2] = usbflg_r[1];
   end

   // Slot s uses nibble 3-(s%4) of register s/4, highest nibble first
   for (genvar s = 0; s < NSLOT; s++) begin : g_live
      localparam logic [3:0] REG = 4'(s / 4);
      localparam int         BIT = 15 - 4 * (s % 4);
      logic [15:0] wm;
      assign wm          = prio_wmask(REG);
      assign req_live[s] = req_raw[s] & wm[BIT];
   end

   // Arbitration: highest level wins, lower slot breaks ties, level 0 never
   // by the slot-to-nibble layout above
   always_ff @(posedge clock) begin
      if (!resetn) begin
         core_req_r   <= 1'b0;
         core_level_r <= 4'h0;
         core_slot_r  <= '0;
      end else begin
         logic             hit;
         ipm_level_t       best;
         logic [SLOT_W-1:0] bslot;
         ipm_level_t       lv;
         hit   = 1'b0;
         best  = 4'h0;
         bslot = '0;
         for (int s = 0; s < NSLOT; s++) begin
            lv = prio_r[s / 4][15 - 4 * (s % 4) -: 4];
            if (req_live[s] && lv > best) begin
               hit   = 1'b1;
               best  = lv;
               bslot = SLOT_W'(s);
            end
         end
         core_req_r   <= hit;
         core_level_r <= best;
         core_slot_r  <= bslot;
      end
   end

   assign core_req   = core_req_r;
   assign core_level = core_level_r;
   assign core_slot  = core_slot_r;

endmodule

// ==== rtl/ipm_map.svh ====
`ifndef IPM_MAP_SVH
`define IPM_MAP_SVH

// Register word indices; byte address on APB is four times the index
`define IPM_IDX_CTL0      32'hFFFE0800
`define IPM_IDX_CTL1      32'hFFFE0802
`define IPM_IDX_EXTFLG    32'hFFFE0806
`define IPM_IDX_BANKCTL   32'hFFFE080C
`define IPM_IDX_BANKNUM   32'hFFFE080E
`define IPM_IDX_PRIO01    32'hFFFE0818
`define IPM_IDX_PRIO02    32'hFFFE081A
`define IPM_IDX_PRIO05    32'hFFFE0820
`define IPM_IDX_PRIO06    32'hFFFE0C00
`define IPM_IDX_PRIO07    32'hFFFE0C02
`define IPM_IDX_PRIO08    32'hFFFE0C04
`define IPM_IDX_PRIO09    32'hFFFE0C06
`define IPM_IDX_PRIO10    32'hFFFE0C08
`define IPM_IDX_PRIO11    32'hFFFE0C0A
`define IPM_IDX_PRIO12    32'hFFFE0C0C
`define IPM_IDX_PRIO13    32'hFFFE0C0E
`define IPM_IDX_PRIO14    32'hFFFE0C10
`define IPM_IDX_PRIO15    32'hFFFE0C12
`define IPM_IDX_PRIO16    32'hFFFE0C14
`define IPM_IDX_PRIO17    32'hFFFE0C16
`define IPM_IDX_PRIO18    32'hFFFE0C18
`define IPM_IDX_USBFLG    32'hFFFE0C50
`define IPM_IDX_IRQSTAT   32'hFFFE0C60
`define IPM_IDX_IRQMASK   32'hFFFE0C61

// Writable nibbles of partly or wholly reserved priority registers
`define IPM_WMASK_PRIO05  16'h00FF
`define IPM_WMASK_PRIO13  16'hFFF0
`define IPM_WMASK_PRIO14  16'h000F
`define IPM_WMASK_PRIO15  16'h0000
`define IPM_WMASK_PRIO16  16'hFFF0
`define IPM_WMASK_PRIO17  16'hFFF0
`define IPM_WMASK_FULL    16'hFFFF

// Strobes of halfword and word accesses
`define IPM_STRB_HALF     4'h3
`define IPM_STRB_WORD     4'hF

// Reset values
`define IPM_RST_ZERO      16'h0000
`define IPM_RST_CTL0      16'h0000

// Request slots fed from the flag registers
`define IPM_SLOT_EP1      6'h3E
`define IPM_SLOT_EP2      6'h3F

// Interrupt status bit positions
`define IPM_ST_EXT        0
`define IPM_ST_USB        1
`define IPM_ST_ERR        2
`define IPM_ST_W          3

`endif

// ==== rtl/ipm_pkg.sv ====
package ipm_pkg;
   // Kind of register selected by an address
   typedef enum logic [3:0] {
      IPM_K_NONE,
      IPM_K_PRIO,
      IPM_K_CTL0,
      IPM_K_CTL1,
      IPM_K_EXTFLG,
      IPM_K_BANKCTL,
      IPM_K_BANKNUM,
      IPM_K_USBFLG,
      IPM_K_STAT,
      IPM_K_MASK
   } ipm_kind_e;
   typedef logic [3:0]  ipm_level_t;
   typedef logic [15:0] ipm_word_t;
endpackage

// ==== verif/ipm_monitor.sv ====
`timescale 1ns/1ps
`include "ipm_map.svh"

// Checks of the register bus and arbitration
module ipm_monitor
   import ipm_pkg::*;
#(
   parameter int AW     = 34,
   parameter int SLOT_W = 6
) (
   input wire logic              clock,
   input wire logic              resetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [AW-1:0]     paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [3:0]        pstrb,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              core_req,
   input wire ipm_level_t        core_level,
   input wire logic [SLOT_W-1:0] core_slot,
   input wire logic [15:0]       control0,
   input wire logic [15:0]       control1,
   input wire logic [15:0]       bank_control,
   input wire logic [15:0]       bank_number
);
   localparam logic [33:0] A_CTL1 = {`IPM_IDX_CTL1, 2'b00};  // Byte address of control 1
   wire              xfer = psel && penable && pready;     // Completing edge
   wire       [15:0] wd   = pwdata[15:0];                  // Register half of write data

   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   // Setup and access cycles
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable;
   endsequence

   // Exactly one wait state, then the answer
   AST_ONE_WAIT: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
      else $error("late answer");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("ready held");
   AST_ERR_QUAL: assert property (pslverr |-> pready && psel && penable)
      else $error("stray error");
   AST_ERR_DATA: assert property (pready && (pslverr || pwrite) |-> prdata == 32'h00000000)
      else $error("read data not zero");
   AST_UPPER_ZERO: assert property (pready |-> prdata[31:16] == 16'h0000)
      else $error("upper half set");
   AST_LEVEL_NZ: assert property (core_req |-> core_level != 4'h0)
      else $error("request at level zero");
   // Slots of reserved nibbles never win
   AST_RESV_SLOT: assert property (core_req |->
      !(core_slot inside {8, 9, 43, 44, 45, 46, 48, 49, 50, 51, 55, 59}))
      else $error("reserved slot won");
   // A refused write leaves the control and bank registers unchanged
   AST_REFUSED_KEEP: assert property (xfer && pslverr && pwrite |=>
      $stable(control0) && $stable(control1) && $stable(bank_control) && $stable(bank_number))
      else $error("refused write landed");
   AST_CTL1_WORD: assert property (xfer && pwrite && paddr == A_CTL1 && pstrb == 4'hF |-> pslverr)
      else $error("word write accepted");
   AST_CTL1_HALF: assert property (xfer && pwrite && !pslverr && paddr == A_CTL1 |=>
      control1 == $past(wd))
      else $error("control 1 not written");
endmodule

bind ipm_top ipm_monitor #(.AW(AW), .SLOT_W(SLOT_W)) i_mon (
   .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .core_req(core_req), .core_level(core_level),
   .core_slot(core_slot), .control0(control0), .control1(control1),
   .bank_control(bank_control), .bank_number(bank_number)
);

// ==== verif/ipm_src_model.sv ====
`timescale 1ns/1ps

// Sources: peripherals hold levels, endpoints pulse
module ipm_src_model (
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic [63:0] req_cmd,
   input  wire logic [7:0]  ext_cmd,
   input  wire logic [1:0]  ep_cmd,
   output logic      [63:0] src_req,
   output logic      [7:0]  ext_line,
   output logic             ep1_full_transfer_end,
   output logic             ep2_empty_transfer_end
);
   // Registered, so changes land just after an edge
   always_ff @(posedge clock) begin
      if (!resetn) begin
         src_req                <= '0;
         ext_line               <= '0;
         ep1_full_transfer_end  <= 1'b0;
         ep2_empty_transfer_end <= 1'b0;
      end else begin
         src_req                <= req_cmd;
         ext_line               <= ext_cmd;
         // A held command yields a pulse every second cycle
         ep1_full_transfer_end  <= ep_cmd[0] && !ep1_full_transfer_end;
         ep2_empty_transfer_end <= ep_cmd[1] && !ep2_empty_transfer_end;
      end
   end
endmodule

// ==== verif/interrupt_priority_map_bench.sv ====
`timescale 1ns/1ps
`include "ipm_map.svh"

module interrupt_priority_map_bench;
   import ipm_pkg::*;
   logic        clock = 1'b0;
   logic        resetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [33:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0]  pstrb = 4'h0;
   logic [63:0] req_cmd = '0;   // Peripheral levels
   logic [7:0]  ext_cmd = '0;   // External line levels
   logic [1:0]  ep_cmd = '0;    // Endpoint pulse requests
   logic [31:0] prdata;
   logic        pready, pslverr, core_req, irq;
   logic [63:0] src_req;
   logic [7:0]  ext_line;
   logic        ep1_full_transfer_end, ep2_empty_transfer_end;
   ipm_level_t  core_level;
   logic [5:0]  core_slot;
   logic [15:0] control0, control1, bank_control, bank_number;
   logic [15:0] rd, d, e;       // Read data and random words
   logic        er, w;          // Error seen; slot writable
   logic [3:0]  lv;             // Random nonzero level
   int          n_errors = 0;
   int          cmp_count = 0;
   logic [31:0] ctl [4] = '{`IPM_IDX_CTL0, `IPM_IDX_CTL1, `IPM_IDX_BANKCTL,
                            `IPM_IDX_BANKNUM};
   wire  [63:0] cports = {bank_number, bank_control, control1, control0};

   // 40 MHz clock
   always #12.5 clock = ~clock;

   ipm_top i_dut (
      .clock (clock), .resetn (resetn), .psel (psel), .penable (penable),
      .pwrite (pwrite), .paddr (paddr), .pwdata (pwdata), .pstrb (pstrb),
      .prdata (prdata), .pready (pready), .pslverr (pslverr), .ext_line (ext_line),
      .src_req (src_req), .ep1_full_transfer_end (ep1_full_transfer_end),
      .ep2_empty_transfer_end (ep2_empty_transfer_end), .core_req (core_req),
      .core_level (core_level), .core_slot (core_slot), .control0 (control0),
      .control1 (control1), .bank_control (bank_control),
      .bank_number (bank_number), .irq (irq));

   ipm_src_model i_src (
      .clock (clock), .resetn (resetn), .req_cmd (req_cmd), .ext_cmd (ext_cmd),
      .ep_cmd (ep_cmd), .src_req (src_req), .ext_line (ext_line),
      .ep1_full_transfer_end (ep1_full_transfer_end),
      .ep2_empty_transfer_end (ep2_empty_transfer_end));

   // Priority register index, 01, 02, 05 to 18
   function automatic logic [31:0] pidx(input int k);
      if (k < 2) return 32'hFFFE0818 + 32'(2 * k);
      if (k == 2) return 32'hFFFE0820;
      return 32'hFFFE0C00 + 32'(2 * (k - 3));
   endfunction

   // Nibbles that hold a source
   function automatic logic [15:0] wmask(input int k);
      case (k)
         2: return 16'h00FF;
         10, 13, 14: return 16'hFFF0;
         11: return 16'h000F;
         12: return 16'h0000;
         default: return 16'hFFFF;
      endcase
   endfunction

   // Priority registers taking words
   function automatic logic wide(input int k);
      return k inside {0, 3, 5, 7, 9, 11, 13};
   endfunction

   // One APB transfer, held until ready is sampled high
   task automatic apb(input logic wr, input logic [31:0] ix, input logic [15:0] wv,
                      input logic [3:0] st);
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {ix, 2'b00};
      pwdata  <= {16'h0000, wv};
      pstrb   <= st;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata[15:0];
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk_word(input string nm, input logic [15:0] x, input logic [15:0] g);
      cmp_count++;
      if (g !== x) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, x, g);
      end
   endtask

   task automatic chk_bit(input string nm, input logic x, input logic g);
      cmp_count++;
      if (g !== x) begin
         n_errors++;
         $display("[ERR] %s expected %b seen %b", nm, x, g);
      end
   endtask

   // Halfword read and compare
   task automatic rchk(input string nm, input logic [31:0] ix, input logic [15:0] x);
      apb(1'b0, ix, 16'h0000, 4'h0);
      chk_word(nm, x, rd);
   endtask

   task automatic give_verdict;
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // Main sequence
   initial begin
      void'($urandom(17));
      repeat (16) @(posedge clock);
      resetn <= 1'b1;
      for (int k = 0; k < 16; k++) rchk("prio_rst", pidx(k), 16'h0000);
      foreach (ctl[i]) rchk("ctl_rst", ctl[i], 16'h0000);
      rchk("ext_rst", `IPM_IDX_EXTFLG, 16'h0000);
      rchk("usb_rst", `IPM_IDX_USBFLG, 16'h0000);
      $display("test reset_values done");
      // Halfword then word writes to each priority register
      for (int k = 0; k < 16; k++) begin
         d = 16'($urandom);
         e = 16'($urandom);
         apb(1'b1, pidx(k), d, 4'h3);
         rchk("prio_half", pidx(k), d & wmask(k));
         apb(1'b1, pidx(k), e, 4'hF);
         chk_bit("prio_word_err", !wide(k), er);
         rchk("prio_word", pidx(k), (wide(k) ? e : d) & wmask(k));
         apb(1'b1, pidx(k), 16'h0000, 4'h3);
      end
      // Control and bank registers, word then halfword
      foreach (ctl[i]) begin
         d = 16'($urandom);
         apb(1'b1, ctl[i], d, 4'hF);
         chk_bit("ctl_word_err", 1'(i % 2), er);
         apb(1'b1, ctl[i], ~d, 4'h3);
         rchk("ctl_half", ctl[i], ~d);
         chk_word("ctl_port", ~d, cports[16*i +: 16]);
      end
      $display("test access_sizes done");
      // Refusals set the bus-error status bit; mask and clear it
      apb(1'b0, 32'hFFFE0804, 16'h0000, 4'h0);
      chk_bit("unmapped_err", 1'b1, er);
      apb(1'b1, `IPM_IDX_CTL0, 16'hFFFF, 4'h1);
      chk_bit("strobe_err", 1'b1, er);
      chk_bit("irq_masked", 1'b0, irq);
      apb(1'b1, `IPM_IDX_IRQMASK, 16'h0004, 4'h3);
      @(posedge clock);
      chk_bit("irq_set", 1'b1, irq);
      apb(1'b1, `IPM_IDX_IRQSTAT, 16'h0004, 4'h3);
      @(posedge clock);
      chk_bit("irq_clear", 1'b0, irq);
      $display("test errors_irq done");
      // Slots 8 to 61 alone at a random level, all peripherals asking
      req_cmd <= '1;
      for (int s = 8; s < 62; s++) begin
         lv = 4'($urandom_range(15, 1));
         apb(1'b1, pidx(s / 4), 16'(lv) << (4 * (3 - s % 4)), 4'h3);
         repeat (3) @(posedge clock);
         e = wmask(s / 4);
         w = e[4 * (3 - s % 4)];
         chk_bit("slot_req", w, core_req);
         if (w) begin
            chk_word("slot_num", 16'(s), 16'(core_slot));
            chk_word("slot_lvl", 16'(lv), 16'(core_level));
         end
         apb(1'b1, pidx(s / 4), 16'h0000, 4'h3);
      end
      foreach (ctl[i]) begin
         apb(1'b1, pidx(3), i[0] ? 16'h5555 : 16'h5F55, 4'h3);
         repeat (3) @(posedge clock);
         chk_word("max_tie", i[0] ? 16'h000C : 16'h000D, 16'(core_slot));
      end
      apb(1'b1, pidx(3), 16'h0000, 4'h3);
      req_cmd <= '0;
      $display("test arbitration done");
      // External edges set flags; read-one then write-zero clears
      for (int i = 0; i < 8; i++) begin
         lv = 4'($urandom_range(15, 1));
         apb(1'b1, pidx(i / 4), 16'(lv) << (4 * (3 - i % 4)), 4'h3);
         ext_cmd[i] <= 1'b1;
         repeat (4) @(posedge clock);
         chk_word("ext_slot", 16'(i), 16'(core_slot));
         apb(1'b1, `IPM_IDX_EXTFLG, 16'h00FF, 4'h3);
         rchk("ext_flag", `IPM_IDX_EXTFLG, 16'h0001 << i);
         apb(1'b1, `IPM_IDX_EXTFLG, 16'h0000, 4'h3);
         rchk("ext_clr", `IPM_IDX_EXTFLG, 16'h0000);
         ext_cmd[i] <= 1'b0;
         apb(1'b1, pidx(i / 4), 16'h0000, 4'h3);
      end
      // Endpoint pulses; endpoint 2 holds the higher level
      apb(1'b1, pidx(15), 16'h0012, 4'h3);
      for (int j = 0; j < 2; j++) begin
         ep_cmd <= 2'(1 << j);
         @(posedge clock);
         ep_cmd <= 2'b00;
         repeat (3) @(posedge clock);
         chk_word("ep_slot", 16'h003E + 16'(j), 16'(core_slot));
      end
      rchk("usb_flag", `IPM_IDX_USBFLG, 16'h0003);
      apb(1'b1, `IPM_IDX_USBFLG, 16'h0000, 4'h3);
      rchk("usb_clr", `IPM_IDX_USBFLG, 16'h0000);
      $display("test flags done");
      give_verdict;
   end

   // Watchdog: about fifteen times the expected run
   initial begin
      #500000;
      n_errors++;
      give_verdict;
   end
endmodule
